//--- design/pin_mux_regs.vh
// register map, field positions and reset values for the configuration and pin mux block
`ifndef PIN_MUX_REGS_VH
`define PIN_MUX_REGS_VH
`define ADDR_STRAP_CAPTURE_0 32'h40000000
`define ADDR_STRAP_CAPTURE_1 32'h40000004
`define ADDR_HOST_PORT_CONFIG 32'h40000008
`define ADDR_HOST_ADDR_TOP_BYTE 32'h4000000c
`define ADDR_HOST_ADDR_UPPER_MID_BYTE 32'h40000010
`define ADDR_TIMER_CAPTURE_SOURCE 32'h40000014
`define ADDR_AUDIO0_MUTE_SELECT 32'h40000018
`define ADDR_AUDIO1_MUTE_SELECT 32'h4000001c
`define ADDR_AUDIO2_MUTE_SELECT 32'h40000020
`define ADDR_BUS_BRIDGE_RESET 32'h40000024
`define ADDR_PIN_MUX_CONFIG 32'h40000028
// host_port_config fields
`define HPC_ENABLE_BIT 0
`define HPC_NONMUXED_BIT 1
`define HPC_OVERRIDE_BIT 2
// timer_capture_source fields: two 3-bit selects
`define TCS_SEL0_LSB 0
`define TCS_SEL1_LSB 4
`define TCS_SEL_W 3
`define TCS_NUM_EVENTS 6
// bus_bridge_reset field
`define BBR_RESET_BIT 0
// pin_mux_config fields
`define PMC_A_OPT_LSB 0
`define PMC_A_OPT_W 2
`define PMC_B_OPT_LSB 4
`define PMC_B_OPT_W 3
`define PMC_OWNER_LSB 8
`define PMC_OWNER_W 6
// option codes
`define A_OPT_SPI_ONLY 2'h0
`define A_OPT_SPI3_TWB 2'h1
`define A_OPT_TWO_WIRE 2'h2
`define B_OPT_5PIN 3'h0
`define B_OPT_4PIN_NO_ENA 3'h1
`define B_OPT_4PIN_NO_SCS 3'h2
`define B_OPT_3PIN 3'h3
`define B_OPT_OFF 3'h4
// reset values
`define RST_ZERO 32'h00000000
// strap capture delay after reset release, covers the pin synchroniser
`define STRAP_CAPTURE_CYCLE 2'h2
`endif

//--- design/device_config_pin_mux.v
// device configuration register bank with apb slave and shared pin multiplexing
//
// Notes on behaviour
// - two strap registers each hold eight pin levels caught at reset release
// - host port config gives host port enable and muxed or non-muxed mode
// - top address byte applies in non-muxed mode or with override enabled
// - upper-middle address byte applies under the same conditions
// - timer capture source picks one of six audio dma events per capture
// - one mute select register per audio port picks its mute input pin
// - bridge register drives reset of the internal bus bridge
// - five port a pins: spi only, spi 3-pin plus two-wire b, two-wire only
// - with two-wire only, slave-in pin stays usable as gpio via port a
// - port b and audio pins share in five options of data pin counts
// - each shared audio data pin owner is selectable per pin
// - pin is output when any enabled sharer drives it
// - with several drivers, fixed highest priority sharer gives the value
// - sampled pin level goes to every sharer at once
`timescale 1ns/10ps
`include "pin_mux_regs.vh"
module device_config_pin_mux #(
  parameter MUTE_SRC_N = 16,
  parameter MUTE_SEL_W = 4
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [7:0] strap_pins_0,
  input wire [7:0] strap_pins_1,
  output wire universal_host_port_enable,
  output wire nonmuxed_host_select,
  output wire host_addr_ext_valid,
  output wire [7:0] host_addr_top_out,
  output wire [7:0] host_addr_upper_mid_out,
  input wire [5:0] audio_dma_events,
  output reg [1:0] timer_capture_in,
  input wire [MUTE_SRC_N-1:0] mute_source_pins,
  output reg audio0_mute_input,
  output reg audio1_mute_input,
  output reg audio2_mute_input,
  output wire internal_bus_bridge_reset,
  input wire [4:0] pad_a_in,
  output reg [4:0] pad_a_out,
  output reg [4:0] pad_a_oe,
  input wire [4:0] spi_a_out,
  input wire [4:0] spi_a_oe,
  output wire [4:0] spi_a_in,
  input wire [1:0] two_wire_a_out,
  input wire [1:0] two_wire_a_oe,
  output wire [1:0] two_wire_a_in,
  input wire [1:0] two_wire_b_out,
  input wire [1:0] two_wire_b_oe,
  output wire [1:0] two_wire_b_in,
  input wire [10:0] pad_b_in,
  output reg [10:0] pad_b_out,
  output reg [10:0] pad_b_oe,
  input wire [10:0] audio_a_data_out,
  input wire [10:0] audio_a_data_oe,
  output wire [10:0] audio_a_data_in,
  input wire [5:0] audio_b_data_out,
  input wire [5:0] audio_b_data_oe,
  output wire [5:0] audio_b_data_in,
  input wire [4:0] spi_b_out,
  input wire [4:0] spi_b_oe,
  output wire [4:0] spi_b_in
);

  localparam RAW_W = MUTE_SRC_N + 32;

  // pick one bit of a vector by index, zero beyond the range
  function pick_bit;
    input [31:0] vec;
    input [31:0] idx;
    input [31:0] lim;
    begin
      if (idx < lim) begin
        pick_bit = vec[idx];
      end else begin
        pick_bit = 1'b0;
      end
    end
  endfunction

  // value from the first of up to three enabled drivers
  function prio3;
    input e0;
    input d0;
    input e1;
    input d1;
    input d2;
    begin
      if (e0) begin
        prio3 = d0;
      end else if (e1) begin
        prio3 = d1;
      end else begin
        prio3 = d2;
      end
    end
  endfunction

  reg [RAW_W-1:0] sync1_ff;
  reg [RAW_W-1:0] sync2_ff;
  reg [1:0] strap_cnt_ff;
  reg strap_done_ff;
  reg [7:0] strap0_ff;
  reg [7:0] strap1_ff;
  reg [2:0] host_cfg_ff;
  reg [7:0] addr_top_ff;
  reg [7:0] addr_mid_ff;
  reg [2:0] cap_sel0_ff;
  reg [2:0] cap_sel1_ff;
  reg [MUTE_SEL_W-1:0] mute0_ff;
  reg [MUTE_SEL_W-1:0] mute1_ff;
  reg [MUTE_SEL_W-1:0] mute2_ff;
  reg bridge_rst_ff;
  reg [1:0] a_opt_ff;
  reg [2:0] b_opt_ff;
  reg [5:0] owner_ff;
  wire [RAW_W-1:0] pins_raw;
  wire [4:0] pa_s;
  wire [10:0] pb_s;
  wire [MUTE_SRC_N-1:0] mute_s;
  wire wr_en;
  reg hit;
  reg [4:0] en_spi_a;
  reg [1:0] en_twa;
  reg [1:0] en_twb;
  reg [10:0] en_aud_a;
  reg [5:0] en_aud_b;
  reg [4:0] en_spi_b;
  reg [10:0] oe_a_b;
  reg [10:0] d_a_b;
  reg [10:0] oe_b_b;
  reg [10:0] d_b_b;
  reg [10:0] oe_s_b;
  reg [10:0] d_s_b;
  integer i;
  integer j;

  // all pin inputs pass two flops before use
  assign pins_raw = {mute_source_pins, strap_pins_1, strap_pins_0, pad_b_in, pad_a_in};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= {RAW_W{1'b0}};
      sync2_ff <= {RAW_W{1'b0}};
    end else begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
    end
  end
  assign pa_s = sync2_ff[4:0];
  assign pb_s = sync2_ff[15:5];
  assign mute_s = sync2_ff[RAW_W-1:32];

  // straps caught once the synchroniser holds post-release levels
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_ff <= 2'h0;
      strap_done_ff <= 1'b0;
      strap0_ff <= 8'h00;
      strap1_ff <= 8'h00;
    end else if (!strap_done_ff) begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == `STRAP_CAPTURE_CYCLE) begin
        strap_done_ff <= 1'b1;
        strap0_ff <= sync2_ff[23:16];
        strap1_ff <= sync2_ff[31:24];
      end
    end
  end

  // apb slave: no wait states, error on unmapped address
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign wr_en = psel & penable & pwrite;

  // address decode and read mux, unused bits read zero
  always @* begin
    hit = 1'b1;
    prdata = `RST_ZERO;
    case (paddr)
      `ADDR_STRAP_CAPTURE_0: prdata = {24'h000000, strap0_ff};
      `ADDR_STRAP_CAPTURE_1: prdata = {24'h000000, strap1_ff};
      `ADDR_HOST_PORT_CONFIG: prdata = {29'h00000000, host_cfg_ff};
      `ADDR_HOST_ADDR_TOP_BYTE: prdata = {24'h000000, addr_top_ff};
      `ADDR_HOST_ADDR_UPPER_MID_BYTE: prdata = {24'h000000, addr_mid_ff};
      `ADDR_TIMER_CAPTURE_SOURCE: prdata = {25'h0000000, cap_sel1_ff, 1'b0, cap_sel0_ff};
      `ADDR_AUDIO0_MUTE_SELECT: prdata[MUTE_SEL_W-1:0] = mute0_ff;
      `ADDR_AUDIO1_MUTE_SELECT: prdata[MUTE_SEL_W-1:0] = mute1_ff;
      `ADDR_AUDIO2_MUTE_SELECT: prdata[MUTE_SEL_W-1:0] = mute2_ff;
      `ADDR_BUS_BRIDGE_RESET: prdata = {31'h00000000, bridge_rst_ff};
      `ADDR_PIN_MUX_CONFIG: prdata = {18'h00000, owner_ff, 1'b0, b_opt_ff, 2'h0, a_opt_ff};
      default: hit = 1'b0;
    endcase
  end

  // register writes take effect in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_cfg_ff <= 3'h0;
      addr_top_ff <= 8'h00;
      addr_mid_ff <= 8'h00;
      cap_sel0_ff <= 3'h0;
      cap_sel1_ff <= 3'h0;
      mute0_ff <= {MUTE_SEL_W{1'b0}};
      mute1_ff <= {MUTE_SEL_W{1'b0}};
      mute2_ff <= {MUTE_SEL_W{1'b0}};
      bridge_rst_ff <= 1'b0;
      a_opt_ff <= `A_OPT_SPI_ONLY;
      b_opt_ff <= `B_OPT_5PIN;
      owner_ff <= 6'h00;
    end else if (wr_en) begin
      case (paddr)
        `ADDR_HOST_PORT_CONFIG: host_cfg_ff <= pwdata[2:0];
        `ADDR_HOST_ADDR_TOP_BYTE: addr_top_ff <= pwdata[7:0];
        `ADDR_HOST_ADDR_UPPER_MID_BYTE: addr_mid_ff <= pwdata[7:0];
        `ADDR_TIMER_CAPTURE_SOURCE: begin
          cap_sel0_ff <= pwdata[`TCS_SEL0_LSB+:`TCS_SEL_W];
          cap_sel1_ff <= pwdata[`TCS_SEL1_LSB+:`TCS_SEL_W];
        end
        `ADDR_AUDIO0_MUTE_SELECT: mute0_ff <= pwdata[MUTE_SEL_W-1:0];
        `ADDR_AUDIO1_MUTE_SELECT: mute1_ff <= pwdata[MUTE_SEL_W-1:0];
        `ADDR_AUDIO2_MUTE_SELECT: mute2_ff <= pwdata[MUTE_SEL_W-1:0];
        `ADDR_BUS_BRIDGE_RESET: bridge_rst_ff <= pwdata[`BBR_RESET_BIT];
        `ADDR_PIN_MUX_CONFIG: begin
          a_opt_ff <= pwdata[`PMC_A_OPT_LSB+:`PMC_A_OPT_W];
          b_opt_ff <= pwdata[`PMC_B_OPT_LSB+:`PMC_B_OPT_W];
          owner_ff <= pwdata[`PMC_OWNER_LSB+:`PMC_OWNER_W];
        end
        default: host_cfg_ff <= host_cfg_ff;
      endcase
    end
  end

  // host port enable, mode and upper address bytes
  assign universal_host_port_enable = host_cfg_ff[`HPC_ENABLE_BIT];
  assign nonmuxed_host_select = host_cfg_ff[`HPC_NONMUXED_BIT];
  assign host_addr_ext_valid = host_cfg_ff[`HPC_NONMUXED_BIT] | host_cfg_ff[`HPC_OVERRIDE_BIT];
  assign host_addr_top_out = host_addr_ext_valid ? addr_top_ff : 8'h00;
  assign host_addr_upper_mid_out = host_addr_ext_valid ? addr_mid_ff : 8'h00;

  // bridge held in reset while the control bit is set
  assign internal_bus_bridge_reset = bridge_rst_ff;

  // timer capture inputs and mute inputs registered from their selected sources
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_capture_in <= 2'h0;
      audio0_mute_input <= 1'b0;
      audio1_mute_input <= 1'b0;
      audio2_mute_input <= 1'b0;
    end else begin
      timer_capture_in[0] <= pick_bit({26'h0, audio_dma_events}, {29'h0, cap_sel0_ff},
                                      `TCS_NUM_EVENTS);
      timer_capture_in[1] <= pick_bit({26'h0, audio_dma_events}, {29'h0, cap_sel1_ff},
                                      `TCS_NUM_EVENTS);
      audio0_mute_input <= pick_bit(mute_s, mute0_ff, MUTE_SRC_N);
      audio1_mute_input <= pick_bit(mute_s, mute1_ff, MUTE_SRC_N);
      audio2_mute_input <= pick_bit(mute_s, mute2_ff, MUTE_SRC_N);
    end
  end

  // port a group: which sharer owns each of the five pins per option
  always @* begin
    en_spi_a = 5'h1f;
    en_twa = 2'h0;
    en_twb = 2'h0;
    case (a_opt_ff)
      `A_OPT_SPI_ONLY: en_spi_a = 5'h1f;
      `A_OPT_SPI3_TWB: begin
        en_spi_a = 5'h07;
        en_twb = 2'h3;
      end
      `A_OPT_TWO_WIRE: begin
        en_spi_a = 5'h02;
        en_twa = 2'h3;
        en_twb = 2'h3;
      end
      default: en_spi_a = 5'h1f;
    endcase
  end

  // port a pads: pin order somi/sda, simo, clk/scl, scs/scl_b, ena/sda_b
  always @* begin
    pad_a_oe[0] = (en_spi_a[0] & spi_a_oe[0]) | (en_twa[0] & two_wire_a_oe[0]);
    pad_a_out[0] = prio3(en_spi_a[0] & spi_a_oe[0], spi_a_out[0], 1'b1,
                         two_wire_a_out[0], 1'b0);
    pad_a_oe[1] = en_spi_a[1] & spi_a_oe[1];
    pad_a_out[1] = spi_a_out[1];
    pad_a_oe[2] = (en_spi_a[2] & spi_a_oe[2]) | (en_twa[1] & two_wire_a_oe[1]);
    pad_a_out[2] = prio3(en_spi_a[2] & spi_a_oe[2], spi_a_out[2], 1'b1,
                         two_wire_a_out[1], 1'b0);
    pad_a_oe[3] = (en_spi_a[3] & spi_a_oe[3]) | (en_twb[1] & two_wire_b_oe[1]);
    pad_a_out[3] = prio3(en_spi_a[3] & spi_a_oe[3], spi_a_out[3], 1'b1,
                         two_wire_b_out[1], 1'b0);
    pad_a_oe[4] = (en_spi_a[4] & spi_a_oe[4]) | (en_twb[0] & two_wire_b_oe[0]);
    pad_a_out[4] = prio3(en_spi_a[4] & spi_a_oe[4], spi_a_out[4], 1'b1,
                         two_wire_b_out[0], 1'b0);
  end

  // sampled pin levels fan out to every sharer
  assign spi_a_in = pa_s;
  assign two_wire_a_in = {pa_s[2], pa_s[0]};
  assign two_wire_b_in = {pa_s[3], pa_s[4]};

  // port b group: spi b pins per option, audio pins take what is left
  always @* begin
    en_spi_b = 5'h00;
    case (b_opt_ff)
      `B_OPT_5PIN: en_spi_b = 5'h1f;
      `B_OPT_4PIN_NO_ENA: en_spi_b = 5'h1d;
      `B_OPT_4PIN_NO_SCS: en_spi_b = 5'h1e;
      `B_OPT_3PIN: en_spi_b = 5'h1c;
      `B_OPT_OFF: en_spi_b = 5'h00;
      default: en_spi_b = 5'h00;
    endcase
    // pins 5..9 go to audio a when spi b leaves them, pins 10..15 always
    en_aud_a = {6'h3f, ~en_spi_b};
    en_aud_b = 6'h00;
    // pins 13..8 carry audio b data 0..5, owner bit i hands data i pin to audio b
    for (i = 0; i < 6; i = i + 1) begin
      if (owner_ff[i] && en_aud_a[10-i-2]) begin
        en_aud_b[i] = 1'b1;
        en_aud_a[10-i-2] = 1'b0;
      end
    end
  end

  // per pin drivers of the port b group, pin index 0 is audio a data 0
  always @* begin
    oe_a_b = en_aud_a & audio_a_data_oe;
    d_a_b = audio_a_data_out;
    oe_b_b = 11'h000;
    d_b_b = 11'h000;
    oe_s_b = 11'h000;
    d_s_b = 11'h000;
    for (j = 0; j < 6; j = j + 1) begin
      oe_b_b[j+3] = en_aud_b[5-j] & audio_b_data_oe[5-j];
      d_b_b[j+3] = audio_b_data_out[5-j];
    end
    // spi b pin order: scs, ena, clk, somi, simo on pins 5..9
    for (j = 0; j < 5; j = j + 1) begin
      oe_s_b[j] = en_spi_b[j] & spi_b_oe[j];
      d_s_b[j] = spi_b_out[j];
    end
    for (j = 0; j < 11; j = j + 1) begin
      pad_b_oe[j] = oe_a_b[j] | oe_b_b[j] | oe_s_b[j];
      pad_b_out[j] = prio3(oe_a_b[j], d_a_b[j], oe_b_b[j], d_b_b[j], d_s_b[j]);
    end
  end

  // every sharer of a port b pin sees the same sampled level
  assign audio_a_data_in = pb_s;
  assign audio_b_data_in = {pb_s[3], pb_s[4], pb_s[5], pb_s[6], pb_s[7], pb_s[8]};
  assign spi_b_in = pb_s[4:0];

endmodule

//--- bench/pin_mux_checker_asserts.sv
// concurrent checks on the ports of the configuration and pin mux block
`timescale 1ns/10ps
`include "pin_mux_regs.vh"
module pin_mux_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire universal_host_port_enable,
  input wire nonmuxed_host_select,
  input wire host_addr_ext_valid,
  input wire [7:0] host_addr_top_out,
  input wire [7:0] host_addr_upper_mid_out,
  input wire [5:0] audio_dma_events,
  input wire [1:0] timer_capture_in,
  input wire internal_bus_bridge_reset,
  input wire [4:0] pad_a_out,
  input wire [4:0] pad_a_oe,
  input wire [4:0] spi_a_out,
  input wire [4:0] spi_a_oe,
  input wire [4:0] spi_a_in,
  input wire [1:0] two_wire_a_in,
  input wire [1:0] two_wire_b_in
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access phase and decoded word
  wire acc = psel && penable;
  wire mapped = paddr >= `ADDR_STRAP_CAPTURE_0 && paddr <= `ADDR_PIN_MUX_CONFIG && !paddr[1:0];
  property p_ready;
    acc |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready in access phase");
  property p_err;
    acc && !mapped |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_host;
    acc && pwrite && paddr == `ADDR_HOST_PORT_CONFIG |=>
      universal_host_port_enable == $past(pwdata[0]) && nonmuxed_host_select == $past(pwdata[1]);
  endproperty
  a_host: assert property (p_host) else $error("host config outputs wrong");
  property p_ext;
    nonmuxed_host_select |-> host_addr_ext_valid;
  endproperty
  a_ext: assert property (p_ext) else $error("upper address not applied");
  property p_zero;
    !host_addr_ext_valid |-> host_addr_top_out == 8'h00 && host_addr_upper_mid_out == 8'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("upper address leaks");
  property p_timer;
    timer_capture_in != 2'h0 |-> $past(audio_dma_events) != 6'h00;
  endproperty
  a_timer: assert property (p_timer) else $error("capture without event");
  property p_bridge;
    acc && pwrite && paddr == `ADDR_BUS_BRIDGE_RESET |=> internal_bus_bridge_reset == $past(pwdata[0]);
  endproperty
  a_bridge: assert property (p_bridge) else $error("bridge reset wrong");
  property p_simo;
    pad_a_oe[1] == spi_a_oe[1] && (!spi_a_oe[1] || pad_a_out[1] == spi_a_out[1]);
  endproperty
  a_simo: assert property (p_simo) else $error("slave-in pin not port a");
  property p_share;
    spi_a_in[0] == two_wire_a_in[0] && spi_a_in[3] == two_wire_b_in[1];
  endproperty
  a_share: assert property (p_share) else $error("shared input differs");
  c_err: cover property (acc && pslverr);
  c_bridge: cover property (internal_bus_bridge_reset);
  c_timer: cover property (timer_capture_in == 2'h3 || timer_capture_in == 2'h2);
endmodule

bind device_config_pin_mux pin_mux_checker pin_mux_checker_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .universal_host_port_enable,
  .nonmuxed_host_select, .host_addr_ext_valid, .host_addr_top_out, .host_addr_upper_mid_out,
  .audio_dma_events, .timer_capture_in, .internal_bus_bridge_reset, .pad_a_out, .pad_a_oe,
  .spi_a_out, .spi_a_oe, .spi_a_in, .two_wire_a_in, .two_wire_b_in);

//--- bench/device_config_pin_mux_test.sv
// register and pin mux tests for the configuration block
`timescale 1ns/10ps
`include "pin_mux_regs.vh"
module device_config_pin_mux_test;
  reg pclk = 0;
  reg presetn = 0;
  reg psel = 0;
  reg penable = 0;
  reg pwrite = 0;
  reg [31:0] paddr = 0;
  reg [31:0] pwdata = 0;
  reg [7:0] strap_pins_0 = 8'ha5;
  reg [7:0] strap_pins_1 = 8'h3c;
  reg [5:0] audio_dma_events = 0;
  reg [5:0] audio_b_data_out = 0;
  reg [5:0] audio_b_data_oe = 0;
  reg [15:0] mute_source_pins = 0;
  reg [4:0] pad_a_in = 0;
  reg [4:0] spi_a_out = 0;
  reg [4:0] spi_a_oe = 0;
  reg [4:0] spi_b_out = 0;
  reg [4:0] spi_b_oe = 0;
  reg [1:0] two_wire_a_out = 0;
  reg [1:0] two_wire_a_oe = 0;
  reg [1:0] two_wire_b_out = 0;
  reg [1:0] two_wire_b_oe = 0;
  reg [10:0] pad_b_in = 0;
  reg [10:0] audio_a_data_out = 0;
  reg [10:0] audio_a_data_oe = 0;
  wire [31:0] prdata;
  wire pready, pslverr, universal_host_port_enable, nonmuxed_host_select, host_addr_ext_valid;
  wire [7:0] host_addr_top_out, host_addr_upper_mid_out;
  wire [1:0] timer_capture_in, two_wire_a_in, two_wire_b_in;
  wire audio0_mute_input, audio1_mute_input, audio2_mute_input, internal_bus_bridge_reset;
  wire [4:0] pad_a_out, pad_a_oe, spi_a_in, spi_b_in;
  wire [10:0] pad_b_out, pad_b_oe, audio_a_data_in;
  wire [5:0] audio_b_data_in;
  integer i;
  integer err_total = 0;
  integer n_compared = 0;
  reg [31:0] rd;
  reg er;
  localparam logic [31:0] rst_v [0:10] = '{32'ha5, 32'h3c, 0, 0, 0, 0, 0, 0, 0, 0, 0};
  localparam logic [31:0] msk [0:10] = '{32'ha5, 32'h3c, 32'h7, 32'hff, 32'hff, 32'h77,
    32'hf, 32'hf, 32'hf, 32'h1, 32'h3f73};
  localparam logic [31:0] pa [0:2] = '{32'h15, 32'h0d, 32'h09};
  localparam logic [31:0] pb [0:5] = '{32'h00, 32'h40, 32'h140, 32'h10, 32'h20, 32'h30};
  localparam logic [31:0] pbo [0:5] = '{32'h01f, 32'h000, 32'h100, 32'h01d, 32'h01e, 32'h01c};
  device_config_pin_mux #(.MUTE_SRC_N(16), .MUTE_SEL_W(4)) device_config_pin_mux_i (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .strap_pins_0, .strap_pins_1, .universal_host_port_enable, .nonmuxed_host_select,
    .host_addr_ext_valid, .host_addr_top_out, .host_addr_upper_mid_out, .audio_dma_events,
    .timer_capture_in, .mute_source_pins, .audio0_mute_input, .audio1_mute_input,
    .audio2_mute_input, .internal_bus_bridge_reset, .pad_a_in, .pad_a_out, .pad_a_oe,
    .spi_a_out, .spi_a_oe, .spi_a_in, .two_wire_a_out, .two_wire_a_oe, .two_wire_a_in,
    .two_wire_b_out, .two_wire_b_oe, .two_wire_b_in, .pad_b_in, .pad_b_out, .pad_b_oe,
    .audio_a_data_out, .audio_a_data_oe, .audio_a_data_in, .audio_b_data_out,
    .audio_b_data_oe, .audio_b_data_in, .spi_b_out, .spi_b_oe, .spi_b_in);
  // clock at 100 mhz
  always #5 pclk = ~pclk;
  // one apb transfer, waits for pready before release
  task xfer(input w, input [31:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  // compare one result
  task chk(input [31:0] e, input [31:0] g);
    n_compared = n_compared + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // let a fixed number of edges pass, then settle
  task edges(input integer n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    #60000;
    err_total = err_total + 1;
    stop_test;
  end
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    edges(4);
    for (i = 0; i < 11; i = i + 1) begin
      xfer(0, 32'h40000000 + 4 * i, 0);
      chk(rst_v[i], rd);
      xfer(1, 32'h40000000 + 4 * i, 32'hffffffff);
      xfer(0, 32'h40000000 + 4 * i, 0);
      chk(msk[i], rd);
    end
    xfer(0, 32'h4000002c, 0);
    chk(32'h1, 32'(er));
    chk(32'h0, rd);
    $display("register map test done");
    xfer(1, `ADDR_HOST_ADDR_TOP_BYTE, 32'h5a);
    xfer(1, `ADDR_HOST_ADDR_UPPER_MID_BYTE, 32'hc3);
    for (i = 0; i < 8; i = i + 1) begin
      xfer(1, `ADDR_HOST_PORT_CONFIG, i);
      chk(32'({i[0], i[1], i[1] | i[2], (i[1] | i[2]) ? 16'h5ac3 : 16'h0}), 32'({
        universal_host_port_enable, nonmuxed_host_select, host_addr_ext_valid,
        host_addr_top_out, host_addr_upper_mid_out}));
    end
    $display("host port test done");
    xfer(1, `ADDR_TIMER_CAPTURE_SOURCE, 32'h52);
    for (i = 0; i < 6; i = i + 1) begin
      @(posedge pclk);
      audio_dma_events <= 6'h1 << i;
      edges(2);
      chk(32'({i == 5, i == 2}), 32'(timer_capture_in));
    end
    xfer(1, `ADDR_AUDIO0_MUTE_SELECT, 32'h3);
    xfer(1, `ADDR_AUDIO1_MUTE_SELECT, 32'h7);
    xfer(1, `ADDR_AUDIO2_MUTE_SELECT, 32'hf);
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge pclk);
      mute_source_pins <= i ? 16'h8080 : 16'h0008;
      edges(5);
      chk(i ? 32'h6 : 32'h1, 32'({audio2_mute_input, audio1_mute_input,
        audio0_mute_input}));
    end
    for (i = 0; i < 2; i = i + 1) begin
      xfer(1, `ADDR_BUS_BRIDGE_RESET, 1 - i);
      chk(1 - i, 32'(internal_bus_bridge_reset));
    end
    $display("timer mute bridge test done");
    @(posedge pclk);
    spi_a_oe <= 5'h1f;
    spi_a_out <= 5'h15;
    two_wire_a_oe <= 2'h3;
    two_wire_a_out <= 2'h1;
    two_wire_b_oe <= 2'h3;
    two_wire_b_out <= 2'h2;
    pad_a_in <= 5'h11;
    for (i = 0; i < 3; i = i + 1) begin
      xfer(1, `ADDR_PIN_MUX_CONFIG, i);
      chk(32'h1f, 32'(pad_a_oe));
      chk(pa[i], 32'(pad_a_out));
    end
    chk(32'h115, 32'({spi_a_in, two_wire_a_in, two_wire_b_in}));
    @(posedge pclk);
    audio_a_data_oe <= 11'h7ff;
    spi_b_oe <= 5'h1f;
    spi_b_out <= 5'h1f;
    audio_b_data_oe <= 6'h3f;
    audio_b_data_out <= 6'h3f;
    for (i = 0; i < 6; i = i + 1) begin
      xfer(1, `ADDR_PIN_MUX_CONFIG, pb[i]);
      chk(32'h7ff, 32'(pad_b_oe));
      chk(pbo[i], 32'(pad_b_out));
    end
    // port b pad levels reach every sharer after the synchroniser
    @(posedge pclk);
    pad_b_in <= 11'h109;
    edges(3);
    chk(32'h109, 32'(audio_a_data_in));
    chk(32'h429, 32'({audio_b_data_in, spi_b_in}));
    $display("pin mux test done");
    stop_test;
  end
endmodule
